/* design/tmr8_consts.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the 8-bit timer.
// Assumes: AHB-Lite word registers at 32-bit aligned offsets.
// Notes: Included by the timer package users only.
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_IRQEN 8'h0c
`define TMR8_OFF_FLAGS 8'h10
`define TMR8_OFF_PRESC 8'h14
`define TMR8_OFF_ACK 8'h18
`define TMR8_CTRL_RESET 8'h00
`define TMR8_IRQEN_RESET 8'h00
`define TMR8_BIT_CMP 1
`define TMR8_BIT_OVF 0
`define TMR8_BIT_PSR 0
`define TMR8_BIT_GIE 1
`define TMR8_BIT_DIR 2
`define TMR8_PRESC_BITS 10
`define TMR8_TOP 8'hff
`define TMR8_BOTTOM 8'h00
`endif

/* design/tmr8_pkg.sv */
// Purpose: Types of the 8-bit timer.
// Assumes: Nothing beyond the constants header.
// Notes: Enumerations follow the field encodings.
package tmr8_pkg;
  typedef enum logic [1:0] {
    TMR8_NORMAL = 2'b00,
    TMR8_PHASE = 2'b01,
    TMR8_CTC = 2'b10,
    TMR8_FAST = 2'b11
  } tmr8_wave_e;
  typedef enum logic [1:0] {
    TMR8_OUT_OFF = 2'b00,
    TMR8_OUT_TOGGLE = 2'b01,
    TMR8_OUT_CLEAR = 2'b10,
    TMR8_OUT_SET = 2'b11
  } tmr8_outmode_e;
  typedef enum logic [2:0] {
    TMR8_CS_STOP = 3'h0,
    TMR8_CS_DIV1 = 3'h1,
    TMR8_CS_DIV8 = 3'h2,
    TMR8_CS_DIV64 = 3'h3,
    TMR8_CS_DIV256 = 3'h4,
    TMR8_CS_DIV1024 = 3'h5,
    TMR8_CS_EXT_FALL = 3'h6,
    TMR8_CS_EXT_RISE = 3'h7
  } tmr8_clksel_e;
endpackage

/* design/tmr8_timer.sv */
// Purpose: 8-bit timer with compare output, clock select, flags and a shared prescaler.
// Assumes: AHB-Lite single word transfers; OKAY always; zero wait states.
// Notes: The 16-bit companion gets its prescaler taps from the port presc_taps.
// Function
// - nonzero output mode takes the pin; driver enabled only with direction bit.
// - non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM: 10 clear on match set at bottom, 11 reverse, 01 reserved.
// - fast PWM with compare at top and upper bit: ignore match, act at bottom.
// - phase PWM: 10 clears on up-match, sets on down-match; 11 inverts.
// - phase PWM with compare at top and upper bit: ignore match, act at top.
// - clock select: stop, direct, four prescaler taps, external falling or rising.
// - external pin counts even when configured as an output.
// - counter read/write; a write blocks the match on the next tick.
// - compare value compared continuously; match feeds flag and waveform.
// - compare interrupt needs its enable, global enable and compare flag.
// - overflow interrupt needs its enable, global enable and overflow flag.
// - compare flag set on match, cleared by vector or write of one.
// - overflow flag set on overflow, or on turnaround at zero in phase mode.
// - both timers use one prescaler with separate clock selects.
// - prescaler runs freely; first count one to N plus one cycles later.
// - prescaler reset restarts the period for every attached timer.
// - prescaler reset bit self-clears, zero writes ignored, reads zero.
// - external pin sampled each clock by registers and a high-transparent latch; here three flops only.
// - one tick per rising edge for 7, falling for 6; no prescaling.
// - counter updates 2.5 to 3.5 cycles after an external edge; here 2 to 3 cycles.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tmr8_consts.svh"
module tmr8_timer
  import tmr8_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_count_pin,
  input wire logic pin_direction,
  input wire logic port_data,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe,
  output logic compare_irq,
  output logic overflow_irq,
  output logic [3:0] presc_taps
);
  // Bus, register, prescaler, sampler and timer state.
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] counter_value_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] irq_en_reg;
  logic global_ie_reg;
  logic compare_flag_reg;
  logic overflow_flag_reg;
  logic psr_reg;
  logic [`TMR8_PRESC_BITS-1:0] presc_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  logic block_reg;
  logic down_reg;
  logic oc_reg;
  logic [3:0] taps_next;
  logic timer_tick;
  logic match;
  logic wave_match;
  logic bus_take;
  logic wr_now;
  tmr8_wave_e wave;
  tmr8_outmode_e omode;
  tmr8_clksel_e csel;

  assign wave = tmr8_wave_e'({ctrl_reg[3], ctrl_reg[6]});
  assign omode = tmr8_outmode_e'(ctrl_reg[5:4]);
  assign csel = tmr8_clksel_e'(ctrl_reg[2:0]);
  assign bus_take = hsel && hready && htrans[1];
  assign wr_now = wr_pend_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_take && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (bus_take && !hwrite) begin
      unique case (haddr[7:0])
        `TMR8_OFF_CTRL: hrdata <= {24'h000000, 1'b0, ctrl_reg[6:0]};
        `TMR8_OFF_COUNT: hrdata <= {24'h000000, counter_value_reg};
        `TMR8_OFF_COMPARE: hrdata <= {24'h000000, compare_value_reg};
        `TMR8_OFF_IRQEN: hrdata <= {24'h000000, irq_en_reg};
        `TMR8_OFF_FLAGS: hrdata <= {30'h0, compare_flag_reg, overflow_flag_reg};
        `TMR8_OFF_PRESC: hrdata <= {30'h0, global_ie_reg, 1'b0};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `TMR8_CTRL_RESET;
      compare_value_reg <= 8'h00;
      irq_en_reg <= `TMR8_IRQEN_RESET;
      global_ie_reg <= 1'b0;
    end else if (wr_now) begin
      if (wr_addr_reg == `TMR8_OFF_CTRL) begin
        ctrl_reg <= {1'b0, hwdata[6:0]};
      end
      if (wr_addr_reg == `TMR8_OFF_COMPARE) begin
        compare_value_reg <= hwdata[7:0];
      end
      if (wr_addr_reg == `TMR8_OFF_IRQEN) begin
        irq_en_reg <= hwdata[7:0];
      end
      if (wr_addr_reg == `TMR8_OFF_PRESC) begin
        global_ie_reg <= hwdata[`TMR8_BIT_GIE];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psr_reg <= 1'b0;
    end else begin
      psr_reg <= wr_now && wr_addr_reg == `TMR8_OFF_PRESC && hwdata[`TMR8_BIT_PSR];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || psr_reg) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  always_comb begin
    taps_next[0] = presc_reg[2:0] == 3'h7;
    taps_next[1] = presc_reg[5:0] == 6'h3f;
    taps_next[2] = presc_reg[7:0] == 8'hff;
    taps_next[3] = presc_reg == 10'h3ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || psr_reg) begin
      presc_taps <= 4'h0;
    end else begin
      presc_taps <= taps_next;
    end
  end

  // The third flop stands in for the high-transparent latch of the sampler.
  // two to three cycle latency from pin edge to count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= external_count_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  always_comb begin
    unique case (csel)
      TMR8_CS_STOP: timer_tick = 1'b0;
      TMR8_CS_DIV1: timer_tick = 1'b1;
      TMR8_CS_DIV8: timer_tick = presc_taps[0];
      TMR8_CS_DIV64: timer_tick = presc_taps[1];
      TMR8_CS_DIV256: timer_tick = presc_taps[2];
      TMR8_CS_DIV1024: timer_tick = presc_taps[3];
      TMR8_CS_EXT_FALL: timer_tick = pin_s3_reg && !pin_s2_reg;
      TMR8_CS_EXT_RISE: timer_tick = !pin_s3_reg && pin_s2_reg;
    endcase
  end

  assign match = counter_value_reg == compare_value_reg && !block_reg;
  assign wave_match = match && !((wave == TMR8_FAST || wave == TMR8_PHASE)
    && compare_value_reg == `TMR8_TOP && omode[1]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (wr_now && wr_addr_reg == `TMR8_OFF_COUNT) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_value_reg <= 8'h00;
      down_reg <= 1'b0;
    end else if (wr_now && wr_addr_reg == `TMR8_OFF_COUNT) begin
      counter_value_reg <= hwdata[7:0];
    end else if (timer_tick) begin
      unique case (wave)
        TMR8_PHASE: begin
          if (!down_reg && counter_value_reg == `TMR8_TOP) begin
            down_reg <= 1'b1;
            counter_value_reg <= counter_value_reg - 8'h01;
          end else if (down_reg && counter_value_reg == `TMR8_BOTTOM) begin
            down_reg <= 1'b0;
            counter_value_reg <= counter_value_reg + 8'h01;
          end else begin
            counter_value_reg <= down_reg ? counter_value_reg - 8'h01 : counter_value_reg + 8'h01;
          end
        end
        TMR8_CTC: begin
          counter_value_reg <= match ? `TMR8_BOTTOM : counter_value_reg + 8'h01;
          down_reg <= 1'b0;
        end
        default: begin
          counter_value_reg <= counter_value_reg + 8'h01;
          down_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_flag_reg <= 1'b0;
    end else if (timer_tick && match) begin
      compare_flag_reg <= 1'b1;
    end else if ((wr_now && wr_addr_reg == `TMR8_OFF_FLAGS && hwdata[`TMR8_BIT_CMP])
      || (wr_now && wr_addr_reg == `TMR8_OFF_ACK && hwdata[`TMR8_BIT_CMP])) begin
      compare_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overflow_flag_reg <= 1'b0;
    end else if (timer_tick && (wave == TMR8_PHASE ? (down_reg && counter_value_reg == `TMR8_BOTTOM)
      : counter_value_reg == `TMR8_TOP)) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_now && (wr_addr_reg == `TMR8_OFF_FLAGS || wr_addr_reg == `TMR8_OFF_ACK)
      && hwdata[`TMR8_BIT_OVF]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      compare_irq <= irq_en_reg[`TMR8_BIT_CMP] && global_ie_reg && compare_flag_reg;
      overflow_irq <= irq_en_reg[`TMR8_BIT_OVF] && global_ie_reg && overflow_flag_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oc_reg <= 1'b0;
    end else if (timer_tick) begin
      unique case (wave)
        TMR8_FAST: begin
          if (wave_match && omode[1]) begin
            oc_reg <= omode[0];
          end else if (counter_value_reg == `TMR8_TOP && omode[1]) begin
            oc_reg <= !omode[0];
          end
        end
        TMR8_PHASE: begin
          if (compare_value_reg == `TMR8_TOP && omode[1]
            && !down_reg && counter_value_reg == `TMR8_TOP) begin
            oc_reg <= !omode[0];
          end else if (wave_match && omode[1]) begin
            oc_reg <= down_reg ? !omode[0] : omode[0];
          end
        end
        default: begin
          if (match) begin
            unique case (omode)
              TMR8_OUT_OFF: oc_reg <= oc_reg;
              TMR8_OUT_TOGGLE: oc_reg <= !oc_reg;
              TMR8_OUT_CLEAR: oc_reg <= 1'b0;
              TMR8_OUT_SET: oc_reg <= 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_output_pin_o <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else begin
      compare_output_pin_o <= (omode != TMR8_OUT_OFF) ? oc_reg : port_data;
      compare_output_pin_oe <= pin_direction;
    end
  end

  // Checks of the rules that this block carries out.
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && match |=> compare_flag_reg) else $error("compare flag not set");
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_n)
    timer_tick && wave == TMR8_NORMAL && counter_value_reg == `TMR8_TOP
    && !(wr_now && wr_addr_reg == `TMR8_OFF_COUNT) |=> overflow_flag_reg
    && counter_value_reg == `TMR8_BOTTOM) else $error("overflow flag not set");
  AST_CMP_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    compare_irq |-> $past(irq_en_reg[`TMR8_BIT_CMP] && global_ie_reg && compare_flag_reg))
    else $error("compare irq without cause");
  AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_irq |-> $past(irq_en_reg[`TMR8_BIT_OVF] && global_ie_reg && overflow_flag_reg))
    else $error("overflow irq without cause");
  AST_PSR_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    psr_reg |=> !psr_reg && presc_reg == 10'h000) else $error("prescaler reset failed");
  AST_DIV8: assert property (@(posedge clk) disable iff (!rst_n)
    presc_taps[0] && !psr_reg |-> ##1 !presc_taps[0] [*7]) else $error("div8 tap too often");
  AST_EXT_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    csel == TMR8_CS_EXT_RISE && !$past(external_count_pin, 3) && $past(external_count_pin, 2)
    |-> timer_tick) else $error("rising edge missed");
  AST_EXT_FALL: assert property (@(posedge clk) disable iff (!rst_n)
    csel == TMR8_CS_EXT_FALL && $past(external_count_pin, 3) && !$past(external_count_pin, 2)
    |-> timer_tick) else $error("falling edge missed");
  AST_EXT_LAT: assert property (@(posedge clk) disable iff (!rst_n)
    csel == TMR8_CS_EXT_RISE && wave == TMR8_NORMAL && !wr_now && !$past(external_count_pin, 3)
    && $past(external_count_pin, 2) |=> counter_value_reg == $past(counter_value_reg) + 8'h01)
    else $error("external edge latency wrong");
  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    csel == TMR8_CS_STOP && !wr_now |=> $stable(counter_value_reg))
    else $error("stopped counter moved");
  AST_PIN_OE: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 compare_output_pin_oe == $past(pin_direction)) else $error("driver enable wrong");
  AST_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    wr_now && wr_addr_reg == `TMR8_OFF_COUNT |=> !match) else $error("write did not block match");
endmodule

/* tb/tmr8_pin_partner.sv */
// Purpose: Far side of the timer: external count source and the compare output pin.
// Assumes: The pin has a pull-up when nobody drives it.
// Notes: The count source is idle low outside a burst of pulses.
`timescale 1ns/1ps
module tmr8_pin_partner (
  input wire logic clk,
  input wire logic compare_output_pin_o,
  input wire logic compare_output_pin_oe,
  output logic external_count_pin,
  output logic pin_level
);
  assign pin_level = compare_output_pin_oe ? compare_output_pin_o : 1'b1;
  initial external_count_pin = 1'b0;
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge clk);
      external_count_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
endmodule

/* tb/tmr8_timer_tb.sv */
// Purpose: Self-checking bench of the 8-bit timer over AHB-Lite.
// Assumes: Zero wait state slave; pin partner drives the count input.
// Notes: Expected values come from integer models in this file.
`timescale 1ns/1ps
`include "tmr8_consts.svh"
module tmr8_timer_tb
  import tmr8_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, hready, pin_direction, port_data;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, oc_o, oc_oe, compare_irq, overflow_irq, ext_pin, pin_level;
  logic [3:0] presc_taps;
  int error_cnt, n_tests, cyc, seed, oc, hi, e, d;
  int dd[2];
  int per[4] = '{8, 64, 256, 1024};
  logic [1:0] tw[6] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};
  logic [1:0] tm[6] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2};
  int tc[6] = '{64, 64, 255, 64, 64, 255};
  tmr8_timer tmr8_timer_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(ext_pin), .pin_direction(pin_direction),
    .port_data(port_data), .compare_output_pin_o(oc_o), .compare_output_pin_oe(oc_oe),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq), .presc_taps(presc_taps));
  tmr8_pin_partner tmr8_pin_partner_i (.clk(clk), .compare_output_pin_o(oc_o),
    .compare_output_pin_oe(oc_oe), .external_count_pin(ext_pin), .pin_level(pin_level));
  assign hready = hreadyout;
  always #5 clk = ~clk;
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_tests++;
    if (g !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic near(input string nm, input int ex, input logic [31:0] g, input int tol);
    n_tests++;
    if ($isunknown(g) || int'(g) < ex - tol || int'(g) > ex + tol) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  function automatic logic [31:0] cw(input logic [1:0] w, input logic [1:0] m, input logic [2:0] cs);
    return {24'h0, 1'b0, w[0], m, w[1], cs};
  endfunction
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {hsel, hwrite, pin_direction, port_data} = 4'h0;
    hsize = 3'h2;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 68;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", `TMR8_OFF_CTRL, `TMR8_CTRL_RESET);
    rdc("irqen", `TMR8_OFF_IRQEN, `TMR8_IRQEN_RESET);
    rdc("presc", `TMR8_OFF_PRESC, 32'h0);
    rdc("unmapped", 8'h1c, 32'h0);
    chk("hresp", 32'h0, hresp);
    v = $random(seed);
    wr(`TMR8_OFF_COUNT, {24'h0, v[7:0]});
    repeat (20) @(posedge clk);
    rdc("count", `TMR8_OFF_COUNT, {24'h0, v[7:0]});
    wr(`TMR8_OFF_COMPARE, {24'h0, v[15:8]});
    rdc("compare", `TMR8_OFF_COMPARE, {24'h0, v[15:8]});
    pin_direction <= 1'b1;
    for (int cs = 6; cs < 8; cs++) begin
      wr(`TMR8_OFF_CTRL, 32'h0);
      wr(`TMR8_OFF_COUNT, 32'h0);
      wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, TMR8_OUT_OFF, cs[2:0]));
      tmr8_pin_partner_i.pulse(5);
      rdc("ext count", `TMR8_OFF_COUNT, 32'h5);
    end
    wr(`TMR8_OFF_CTRL, 32'h0);
    tmr8_pin_partner_i.pulse(2);
    rdc("stopped", `TMR8_OFF_COUNT, 32'h5);
    wr(`TMR8_OFF_FLAGS, 32'h3);
    wr(`TMR8_OFF_COMPARE, 32'hff);
    wr(`TMR8_OFF_COUNT, 32'hfd);
    wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, TMR8_OUT_OFF, TMR8_CS_EXT_RISE));
    tmr8_pin_partner_i.pulse(4);
    rdc("wrap", `TMR8_OFF_COUNT, 32'h1);
    rdc("flags", `TMR8_OFF_FLAGS, 32'h3);
    for (int k = 0; k < 8; k++) begin
      wr(`TMR8_OFF_IRQEN, k & 3);
      wr(`TMR8_OFF_PRESC, (k >> 1) & 2);
      repeat (2) @(posedge clk);
      chk("compare_irq", k[1] & k[2], compare_irq);
      chk("overflow_irq", k[0] & k[2], overflow_irq);
    end
    wr(`TMR8_OFF_PRESC, 32'h0);
    wr(`TMR8_OFF_FLAGS, 32'h0);
    rdc("flags zero write", `TMR8_OFF_FLAGS, 32'h3);
    wr(`TMR8_OFF_ACK, 32'h2);
    rdc("flags ack", `TMR8_OFF_FLAGS, 32'h1);
    wr(`TMR8_OFF_FLAGS, 32'h1);
    rdc("flags w1c", `TMR8_OFF_FLAGS, 32'h0);
    oc = 0;
    wr(`TMR8_OFF_COMPARE, 32'h40);
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 3 : (i == 1) ? 2 : 1;
      oc = (e == 3) ? 1 : (e == 2) ? 0 : 1 - oc;
      wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, e[1:0], TMR8_CS_EXT_RISE));
      wr(`TMR8_OFF_COUNT, 32'h3d);
      tmr8_pin_partner_i.pulse(4);
      chk("oc pin", oc, oc_o);
      chk("oc enable", 32'h1, oc_oe);
    end
    port_data <= 1'b1;
    wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, TMR8_OUT_OFF, TMR8_CS_EXT_RISE));
    repeat (3) @(posedge clk);
    chk("port pin", 32'h1, oc_o);
    pin_direction <= 1'b0;
    wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, TMR8_OUT_CLEAR, TMR8_CS_EXT_RISE));
    repeat (3) @(posedge clk);
    chk("oc disabled", 32'h0, oc_oe);
    pin_direction <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      d = (tw[r] == TMR8_FAST) ? 512 : 510;
      e = (tw[r] == TMR8_FAST) ? 2 * (tc[r] + 1) : 2 * tc[r];
      e = (tc[r] == 255) ? d : e;
      e = (tm[r] == 2'h3) ? d - e : e;
      wr(`TMR8_OFF_COMPARE, tc[r]);
      wr(`TMR8_OFF_CTRL, cw(tw[r], tm[r], TMR8_CS_DIV1));
      repeat (600) @(posedge clk);
      hi = 0;
      repeat (d) begin
        @(posedge clk);
        if (pin_level === 1'b1) hi++;
      end
      near("pwm high cycles", e, hi, 4);
    end
    wr(`TMR8_OFF_PRESC, 32'h1);
    rdc("presc reset", `TMR8_OFF_PRESC, 32'h0);
    for (int k = 0; k < 4; k++) begin
      d = 0;
      while (presc_taps[k] !== 1'b1 && d < 2100) begin
        @(posedge clk);
        d++;
      end
      d = 0;
      do begin
        @(posedge clk);
        d++;
      end while (presc_taps[k] !== 1'b1 && d < 2100);
      chk("tap period", per[k], d);
    end
    for (int r = 0; r < 2; r++) begin
      repeat (($random(seed) & 255) + 1) @(posedge clk);
      wr(`TMR8_OFF_PRESC, 32'h1);
      repeat (2) @(posedge clk);
      d = 0;
      while (presc_taps[3] !== 1'b1 && d < 2100) begin
        @(posedge clk);
        d++;
      end
      dd[r] = d;
    end
    chk("reset phase", dd[0], dd[1]);
    for (int cs = 1; cs < 6; cs++) begin
      d = (cs == 1) ? 100 : 1024;
      e = (cs == 1) ? 1 : per[cs - 2];
      wr(`TMR8_OFF_CTRL, 32'h0);
      wr(`TMR8_OFF_COUNT, 32'h0);
      wr(`TMR8_OFF_CTRL, cw(TMR8_NORMAL, TMR8_OUT_OFF, cs[2:0]));
      repeat (d) @(posedge clk);
      wr(`TMR8_OFF_CTRL, 32'h0);
      bus(1'b0, `TMR8_OFF_COUNT, 32'h0);
      near("rate count", (d + 3) / e, rd, 2);
    end
    results();
  end
endmodule
